// [testbench/pad_dejitter_power_config_tb.sv]
// Purpose: bench for pad_dejitter_power_config
// Assumes: inputs change on the falling edge
// Notes: two strobes a set spacing apart probe the window
`timescale 1ns/1ps
module pad_dejitter_power_config_tb;
   reg core_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
   reg strobeAsync = 1'b0;
   reg [15:0] regAddr = 16'h0;
   reg [7:0] regWrData = 8'h0;
   reg [23:0] sample = 24'h5a3c96;
   wire [7:0] regRdData;
   wire regRdValid, regHit, adcEn, dmicEn, dacEn, memAccessEn, engineEn;
   wire serialPortEn, recordRouteEn, playbackRouteEn, clockGenEn;
   wire dejitterBypass, playStrobe, recStrobe, mckDrv, mckUp, mckDn;
   wire [1:0] pullD, pullL, pullC, pullO;
   wire [3:0] upEn, dnEn, drvHi;
   wire [23:0] playData, recData;
   integer miscompares = 0, numChecks = 0, playCnt = 0, recCnt = 0, k;
   pad_dejitter_power_config pad_dejitter_power_config_inst (
      .core_clk, .rst, .regAddr, .regWr, .regRd, .regWrData, .regRdData,
      .regRdValid, .regHit, .control_data_pin_pull(pullD),
      .control_latch_pin_pull(pullL), .control_clock_pin_pull(pullC),
      .control_data_out_pin_pull(pullO), .padPullUpEn(upEn),
      .padPullDownEn(dnEn), .padDriveHigh(drvHi),
      .master_clock_out_pin_drive(mckDrv),
      .master_clock_out_pin_pullup(mckUp),
      .master_clock_out_pin_pulldown(mckDn), .adcEn, .dmicEn, .dacEn,
      .memAccessEn, .engineEn, .serialPortEn, .recordRouteEn,
      .playbackRouteEn, .clockGenEn, .dejitterBypass,
      .playStrobeAsync(strobeAsync), .playDataAsync(sample), .playStrobe,
      .playData, .recFrameAsync(strobeAsync), .recDataIn(sample),
      .recStrobe, .recData
   );
   initial forever #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (playStrobe === 1'b1) playCnt = playCnt + 1;
      if (recStrobe === 1'b1) recCnt = recCnt + 1;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         numChecks = numChecks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", numChecks, miscompares);
         if (miscompares == 0 && numChecks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      begin
         @(negedge core_clk);
         regAddr = a;
         regWrData = d;
         regWr = 1'b1;
         @(negedge core_clk) regWr = 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [7:0] exp);
      begin
         @(negedge core_clk);
         regAddr = a;
         regRd = 1'b1;
         @(negedge core_clk) regRd = 1'b0;
         chk(regRdValid, 1'b1);
         chk(regRdData, exp);
      end
   endtask
   // two rises sp cycles apart, then count what came out
   task burst(input integer np, input integer nr, input integer sp);
      begin
         playCnt = 0;
         recCnt = 0;
         sample = sample + 24'h010101;
         repeat (2) begin
            @(negedge core_clk) strobeAsync = 1'b1;
            @(negedge core_clk) strobeAsync = 1'b0;
            repeat (sp - 2) @(negedge core_clk);
         end
         repeat (10) @(negedge core_clk);
         chk(playCnt, np);
         chk(recCnt, nr);
         if (np > 0) chk(playData, sample);
         if (nr > 0) chk(recData, sample);
      end
   endtask
   task t_reset;
      begin
         chk({upEn, dnEn}, 8'h4b);
         chk({mckDrv, mckUp, mckDn}, 3'h1);
         rd(16'h402f, 8'hcf);
         rd(16'h4030, 8'h00);
         rd(16'h4031, 8'h01);
         rd(16'h4032, 8'h05);
         rd(16'h4080, 8'h00);
         chk(regHit, 1'b1);
         chk({adcEn, engineEn, clockGenEn}, 3'h0);
      end
   endtask
   task t_pads;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            wr(16'h402f, {4{k[1:0]}});
            chk({pullD, pullL, pullC, pullO}, {4{k[1:0]}});
            chk(upEn, (k == 0) ? 4'hf : 4'h0);
            chk(dnEn, (k == 3) ? 4'hf : 4'h0);
         end
         wr(16'h4030, 8'hfa);
         chk(drvHi, 4'ha);
         rd(16'h4030, 8'h0a);
         wr(16'h4031, 8'hfe);
         chk({mckDrv, mckUp, mckDn}, 3'h6);
         rd(16'h4031, 8'h06);
         rd(16'h4033, 8'h00);
         chk(regHit, 1'b0);
      end
   endtask
   task t_power;
      reg [7:0] v;
      begin
         for (k = 0; k < 9; k = k + 1) begin
            v = (k == 8) ? 8'hc1 : 8'h01 << k;
            wr(16'h4080, v);
            chk({adcEn, dmicEn}, {v[7] & v[6], v[7]});
            chk({dacEn, memAccessEn}, {v[6], v[6]});
            chk({engineEn, clockGenEn}, {v[0] & v[6], v[1]});
            chk(serialPortEn, v[5] | v[4]);
            chk(recordRouteEn, v[3]);
            chk(playbackRouteEn, v[2]);
         end
      end
   endtask
   task t_jitter;
      begin
         wr(16'h4080, 8'hff);
         burst(1, 1, 3);
         burst(1, 1, 5);
         burst(2, 2, 6);
         wr(16'h4032, 8'h00);
         chk(dejitterBypass, 1'b1);
         burst(2, 2, 3);
         wr(16'h4032, 8'h00);
         wr(16'h4032, 8'h05);
         chk(dejitterBypass, 1'b0);
         burst(1, 1, 3);
         wr(16'h4080, 8'hf7);
         burst(1, 0, 3);
         wr(16'h4080, 8'hfb);
         burst(0, 1, 3);
         wr(16'h4080, 8'hfe);
         burst(1, 0, 3);
         wr(16'h4080, 8'h4f);
         burst(0, 0, 3);
      end
   endtask
   // reset again in mid-run, registers must return to defaults
   task t_rereset;
      begin
         wr(16'h4032, 8'h00);
         wr(16'h402f, 8'h00);
         @(negedge core_clk) rst = 1'b1;
         repeat (3) @(negedge core_clk);
         rst = 1'b0;
         chk(dejitterBypass, 1'b0);
         chk({upEn, dnEn}, 8'h4b);
         chk({adcEn, serialPortEn, engineEn}, 3'h0);
         rd(16'h4032, 8'h05);
         rd(16'h402f, 8'hcf);
      end
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      t_reset;
      t_pads;
      t_power;
      t_jitter;
      t_rereset;
      summarize;
   end
   initial begin
      #200000;
      miscompares = miscompares + 1;
      summarize;
   end
endmodule // pad_dejitter_power_config_tb

// [testbench/pad_dejitter_props_properties.sv]
// Purpose: port checks for pad_dejitter_power_config
// Assumes: one clock, synchronous reset
// Notes: bound after the module
`timescale 1ns/1ps
module pad_dejitter_props (
   // clock and reset
   input wire core_clk, rst,
   // register port
   input wire regWr, regRd, regRdValid, regHit,
   input wire [15:0] regAddr,
   input wire [7:0] regWrData, regRdData,
   // pads
   input wire [1:0] control_data_pin_pull, control_clock_pin_pull,
   input wire [3:0] padPullUpEn, padPullDownEn, padDriveHigh,
   input wire master_clock_out_pin_pulldown,
   // enables and samples
   input wire adcEn, dmicEn, memAccessEn, engineEn, serialPortEn,
   input wire dejitterBypass, playStrobe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_ans; ##1 regRdValid; endsequence
   sequence s_gap; ##1 !playStrobe; endsequence
   property p_rdv; regRd |-> s_ans; endproperty
   a_rdv: assert property (p_rdv)
      else $error("read answer missing");
   property p_pull0; $fell(rst) |-> control_data_pin_pull == 2'h3
      && control_clock_pin_pull == 2'h3; endproperty
   a_pull0: assert property (p_pull0)
      else $error("pull reset value");
   property p_drv0; $fell(rst) |-> padDriveHigh == 4'h0
      && master_clock_out_pin_pulldown && !dejitterBypass; endproperty
   a_drv0: assert property (p_drv0)
      else $error("drive reset value");
   property p_up; padPullUpEn[3] == (control_data_pin_pull == 2'h0);
   endproperty
   a_up: assert property (p_up)
      else $error("pull-up decode");
   property p_dn; padPullDownEn[1] == (control_clock_pin_pull == 2'h3);
   endproperty
   a_dn: assert property (p_dn)
      else $error("pull-down decode");
   property p_adc; adcEn == (dmicEn && memAccessEn); endproperty
   a_adc: assert property (p_adc)
      else $error("converter gating");
   property p_eng; engineEn |-> memAccessEn; endproperty
   a_eng: assert property (p_eng)
      else $error("engine without memory");
   property p_gate; regWr && regAddr == 16'h4080 |=>
      serialPortEn == $past(|regWrData[5:4]); endproperty
   a_gate: assert property (p_gate)
      else $error("serial port gate");
   property p_byp; regWr && regAddr == 16'h4032 |=>
      dejitterBypass == ($past(regWrData) == 8'h00); endproperty
   a_byp: assert property (p_byp)
      else $error("bypass flag");
   property p_rsv; regRdValid && $past(regAddr) == 16'h4030 |->
      regRdData[7:4] == 4'h0; endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved bits read");
   property p_pulse; playStrobe |-> s_gap; endproperty
   a_pulse: assert property (p_pulse)
      else $error("sample strobe width");
   // gap since the last sample strobe, and the window that governs it
   reg [7:0] winShadow_r, gapCnt_r;
   reg winMoved_r, seen_r;
   always @(posedge core_clk) begin
      if (rst) begin
         winShadow_r <= 8'h05;
         gapCnt_r <= 8'h00;
         winMoved_r <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         if (regWr && regAddr == 16'h4032) begin
            winShadow_r <= regWrData;
            winMoved_r <= 1'b1;
         end else if (playStrobe) begin
            winMoved_r <= 1'b0;
         end
         if (playStrobe) begin
            gapCnt_r <= 8'h00;
            seen_r <= 1'b1;
         end else if (gapCnt_r != 8'hff) begin
            gapCnt_r <= gapCnt_r + 8'h01;
         end
      end
   end
   property p_hold; playStrobe && seen_r && !winMoved_r |->
      gapCnt_r >= winShadow_r; endproperty
   a_hold: assert property (p_hold)
      else $error("sample inside window");
endmodule // pad_dejitter_props
bind pad_dejitter_power_config pad_dejitter_props pad_dejitter_props_inst (
   .core_clk, .rst, .regWr, .regRd, .regRdValid, .regHit, .regAddr,
   .regWrData, .regRdData, .control_data_pin_pull,
   .control_clock_pin_pull, .padPullUpEn, .padPullDownEn,
   .padDriveHigh, .master_clock_out_pin_pulldown, .adcEn, .dmicEn,
   .memAccessEn, .engineEn, .serialPortEn, .dejitterBypass, .playStrobe
);

// [verilog/jitter_window_filter.v]
// Purpose: one dejitter circuit, holds off repeated sample strobes
// Assumes: strobeIn is a one-cycle pulse already on core_clk
// Notes: zero window bypasses the circuit and clears its hold count
`timescale 1ns/1ps
module jitter_window_filter #(
   parameter DATA_W = 24
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // control
   input wire [7:0] windowSize,
   // sample in
   input wire strobeIn,
   input wire [DATA_W-1:0] dataIn,
   // sample out
   output wire strobeOut,
   output wire [DATA_W-1:0] dataOut
);
   reg [7:0] holdCnt_r;
   reg strobe_r;
   reg [DATA_W-1:0] data_r;
   wire bypass;
   wire accept;

   assign bypass = (windowSize == 8'h00);
   // a strobe inside the open window is a duplicate and is dropped
   assign accept = strobeIn & (bypass | (holdCnt_r == 8'h00));

   always @(posedge core_clk) begin
      if (rst) begin
         holdCnt_r <= 8'h00;
         strobe_r <= 1'b0;
         data_r <= {DATA_W{1'b0}};
      end else begin
         strobe_r <= accept;
         if (accept) begin
            data_r <= dataIn;
         end
         if (bypass) begin
            holdCnt_r <= 8'h00;
         end else if (accept) begin
            holdCnt_r <= windowSize;
         end else if (holdCnt_r != 8'h00) begin
            holdCnt_r <= holdCnt_r - 8'h01;
         end
      end
   end

   assign strobeOut = strobe_r;
   assign dataOut = data_r;
endmodule // jitter_window_filter

// [verilog/pad_dejitter_consts.vh]
// Purpose: offsets, field positions and reset values of the pad,
//          jitter window and digital power gate registers
// Assumes: 16-bit register addresses, 8-bit register data
// Notes: definitions only
`ifndef PAD_DEJITTER_CONSTS_VH
`define PAD_DEJITTER_CONSTS_VH

// register offsets
`define OFS_PAD_PULL 16'h402f
`define OFS_PAD_DRIVE 16'h4030
`define OFS_CLKOUT_PAD 16'h4031
`define OFS_JITTER_WIN 16'h4032
`define OFS_POWER_GATE0 16'h4080

// reset values
`define RST_PAD_PULL 8'hcf
`define RST_PAD_DRIVE 8'h00
`define RST_CLKOUT_PAD 8'h01
`define RST_JITTER_WIN 8'h05
`define RST_POWER_GATE0 8'h00

// writable bit masks, reserved bits clear
`define MASK_PAD_PULL 8'hff
`define MASK_PAD_DRIVE 8'h0f
`define MASK_CLKOUT_PAD 8'h07
`define MASK_JITTER_WIN 8'hff
`define MASK_POWER_GATE0 8'hff

// pull field positions (low bit of each two-bit field)
`define POS_PULL_DATA 6
`define POS_PULL_LATCH 4
`define POS_PULL_CLOCK 2
`define POS_PULL_DOUT 0

// pull codes
`define PULL_UP 2'h0
`define PULL_RSVD 2'h1
`define PULL_NONE 2'h2
`define PULL_DOWN 2'h3

// drive bits
`define BIT_DRV_DATA 3
`define BIT_DRV_LATCH 2
`define BIT_DRV_CLOCK 1
`define BIT_DRV_DOUT 0

// clock out pad bits
`define BIT_CKO_DRIVE 2
`define BIT_CKO_PULLUP 1
`define BIT_CKO_PULLDN 0

// power gate bits
`define BIT_PG_ADC 7
`define BIT_PG_MEM 6
`define BIT_PG_XFER 5
`define BIT_PG_SPORT 4
`define BIT_PG_RECROUTE 3
`define BIT_PG_PLAYROUTE 2
`define BIT_PG_CLKGEN 1
`define BIT_PG_ENGINE 0

`endif

// [verilog/pad_dejitter_power_config.v]
// Purpose: pad pull and drive config, jitter window and power gates
// Assumes: control port decoder gives single-cycle reads and writes
// Notes: reads answer one cycle after regRd with regRdValid
`timescale 1ns/1ps
`include "pad_dejitter_consts.vh"
module pad_dejitter_power_config #(
   parameter DATA_W = 24
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // control port register access
   input wire [15:0] regAddr,
   input wire regWr,
   input wire regRd,
   input wire [7:0] regWrData,
   output wire [7:0] regRdData,
   output wire regRdValid,
   output wire regHit,
   // control port pad settings
   output wire [1:0] control_data_pin_pull,
   output wire [1:0] control_latch_pin_pull,
   output wire [1:0] control_clock_pin_pull,
   output wire [1:0] control_data_out_pin_pull,
   output wire [3:0] padPullUpEn,
   output wire [3:0] padPullDownEn,
   output wire [3:0] padDriveHigh,
   // master clock out pad settings
   output wire master_clock_out_pin_drive,
   output wire master_clock_out_pin_pullup,
   output wire master_clock_out_pin_pulldown,
   // subsystem enables
   output wire adcEn,
   output wire dmicEn,
   output wire dacEn,
   output wire memAccessEn,
   output wire engineEn,
   output wire serialPortEn,
   output wire recordRouteEn,
   output wire playbackRouteEn,
   output wire clockGenEn,
   output wire dejitterBypass,
   // serial input sample (serial port domain)
   input wire playStrobeAsync,
   input wire [DATA_W-1:0] playDataAsync,
   output wire playStrobe,
   output wire [DATA_W-1:0] playData,
   // record sample toward serial port (strobe from port frame)
   input wire recFrameAsync,
   input wire [DATA_W-1:0] recDataIn,
   output wire recStrobe,
   output wire [DATA_W-1:0] recData
);
   reg [7:0] padPull_r;
   reg [7:0] padDrive_r;
   reg [7:0] clkOutPad_r;
   reg [7:0] jitterWin_r;
   reg [7:0] powerGate_r;
   reg [7:0] rdData_r;
   reg rdValid_r;
   reg [2:0] playSync_r;
   reg [2:0] recSync_r;
   reg [7:0] rdData_nxt;
   reg hit_nxt;
   reg [7:0] padPull_nxt;
   reg [7:0] padDrive_nxt;
   reg [7:0] clkOutPad_nxt;
   reg [7:0] jitterWin_nxt;
   reg [7:0] powerGate_nxt;
   reg [3:0] pullUp_r;
   reg [3:0] pullDown_r;
   reg adcEn_r;
   reg dmicEn_r;
   reg dacEn_r;
   reg memEn_r;
   reg engineEn_r;
   reg serialEn_r;
   reg recRouteEn_r;
   reg playRouteEn_r;
   reg clkGenEn_r;
   reg bypass_r;
   reg [DATA_W-1:0] playMeta_r;
   reg [DATA_W-1:0] playSyncData_r;
   wire playEdge;
   wire recEdge;
   wire playRaw;
   wire recRaw;

   // pull code to pull-up / pull-down enables; reserved code acts as none
   function [1:0] pull_decode;
      input [1:0] code;
      begin
         case (code)
            `PULL_UP: pull_decode = 2'h2;
            `PULL_DOWN: pull_decode = 2'h1;
            default: pull_decode = 2'h0;
         endcase
      end
   endfunction

   // whole pull register to {pull-up enables, pull-down enables}
   function [7:0] pull_enables;
      input [7:0] pullReg;
      reg [1:0] dataDec;
      reg [1:0] latchDec;
      reg [1:0] clockDec;
      reg [1:0] doutDec;
      begin
         dataDec = pull_decode(pullReg[`POS_PULL_DATA+1:`POS_PULL_DATA]);
         latchDec = pull_decode(pullReg[`POS_PULL_LATCH+1:`POS_PULL_LATCH]);
         clockDec = pull_decode(pullReg[`POS_PULL_CLOCK+1:`POS_PULL_CLOCK]);
         doutDec = pull_decode(pullReg[`POS_PULL_DOUT+1:`POS_PULL_DOUT]);
         pull_enables = {dataDec[1], latchDec[1], clockDec[1], doutDec[1],
            dataDec[0], latchDec[0], clockDec[0], doutDec[0]};
      end
   endfunction

   // address decode and read mux
   always @* begin
      rdData_nxt = 8'h00;
      hit_nxt = 1'b1;
      case (regAddr)
         `OFS_PAD_PULL: rdData_nxt = padPull_r;
         `OFS_PAD_DRIVE: rdData_nxt = padDrive_r;
         `OFS_CLKOUT_PAD: rdData_nxt = clkOutPad_r;
         `OFS_JITTER_WIN: rdData_nxt = jitterWin_r;
         `OFS_POWER_GATE0: rdData_nxt = powerGate_r;
         default: hit_nxt = 1'b0;
      endcase
   end

   assign regHit = hit_nxt;

   // next register values; reserved bits masked off on write
   always @* begin
      padPull_nxt = padPull_r;
      padDrive_nxt = padDrive_r;
      clkOutPad_nxt = clkOutPad_r;
      jitterWin_nxt = jitterWin_r;
      powerGate_nxt = powerGate_r;
      if (regWr) begin
         case (regAddr)
            `OFS_PAD_PULL:
               padPull_nxt = regWrData & `MASK_PAD_PULL;
            `OFS_PAD_DRIVE:
               padDrive_nxt = regWrData & `MASK_PAD_DRIVE;
            `OFS_CLKOUT_PAD:
               clkOutPad_nxt = regWrData & `MASK_CLKOUT_PAD;
            `OFS_JITTER_WIN:
               jitterWin_nxt = regWrData & `MASK_JITTER_WIN;
            `OFS_POWER_GATE0:
               powerGate_nxt = regWrData & `MASK_POWER_GATE0;
            default: ;
         endcase
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         padPull_r <= `RST_PAD_PULL;
         padDrive_r <= `RST_PAD_DRIVE;
         clkOutPad_r <= `RST_CLKOUT_PAD;
         jitterWin_r <= `RST_JITTER_WIN;
         powerGate_r <= `RST_POWER_GATE0;
         rdData_r <= 8'h00;
         rdValid_r <= 1'b0;
      end else begin
         rdValid_r <= regRd;
         if (regRd) begin
            rdData_r <= rdData_nxt;
         end
         padPull_r <= padPull_nxt;
         padDrive_r <= padDrive_nxt;
         clkOutPad_r <= clkOutPad_nxt;
         jitterWin_r <= jitterWin_nxt;
         powerGate_r <= powerGate_nxt;
      end
   end

   // decoded pulls and gated enables, loaded from next values so they
   // change on the same edge as the register they come from
   always @(posedge core_clk) begin
      if (rst) begin
         {pullUp_r, pullDown_r} <= pull_enables(`RST_PAD_PULL);
         adcEn_r <= 1'b0;
         dmicEn_r <= 1'b0;
         dacEn_r <= 1'b0;
         memEn_r <= 1'b0;
         engineEn_r <= 1'b0;
         serialEn_r <= 1'b0;
         recRouteEn_r <= 1'b0;
         playRouteEn_r <= 1'b0;
         clkGenEn_r <= 1'b0;
         bypass_r <= 1'b0;
      end else begin
         {pullUp_r, pullDown_r} <= pull_enables(padPull_nxt);
         memEn_r <= powerGate_nxt[`BIT_PG_MEM];
         adcEn_r <= powerGate_nxt[`BIT_PG_ADC] &
            powerGate_nxt[`BIT_PG_MEM];
         dmicEn_r <= powerGate_nxt[`BIT_PG_ADC];
         dacEn_r <= powerGate_nxt[`BIT_PG_MEM];
         engineEn_r <= powerGate_nxt[`BIT_PG_ENGINE] &
            powerGate_nxt[`BIT_PG_MEM];
         serialEn_r <= powerGate_nxt[`BIT_PG_XFER] |
            powerGate_nxt[`BIT_PG_SPORT];
         recRouteEn_r <= powerGate_nxt[`BIT_PG_RECROUTE];
         playRouteEn_r <= powerGate_nxt[`BIT_PG_PLAYROUTE];
         clkGenEn_r <= powerGate_nxt[`BIT_PG_CLKGEN];
         bypass_r <= (jitterWin_nxt == 8'h00);
      end
   end

   assign regRdData = rdData_r;
   assign regRdValid = rdValid_r;

   // pad outputs
   assign control_data_pin_pull =
      padPull_r[`POS_PULL_DATA+1:`POS_PULL_DATA];
   assign control_latch_pin_pull =
      padPull_r[`POS_PULL_LATCH+1:`POS_PULL_LATCH];
   assign control_clock_pin_pull =
      padPull_r[`POS_PULL_CLOCK+1:`POS_PULL_CLOCK];
   assign control_data_out_pin_pull =
      padPull_r[`POS_PULL_DOUT+1:`POS_PULL_DOUT];
   assign padPullUpEn = pullUp_r;
   assign padPullDownEn = pullDown_r;
   assign padDriveHigh = {padDrive_r[`BIT_DRV_DATA],
      padDrive_r[`BIT_DRV_LATCH], padDrive_r[`BIT_DRV_CLOCK],
      padDrive_r[`BIT_DRV_DOUT]};
   assign master_clock_out_pin_drive = clkOutPad_r[`BIT_CKO_DRIVE];
   // stored bit driven as written, one enables the pull-up
   assign master_clock_out_pin_pullup = clkOutPad_r[`BIT_CKO_PULLUP];
   assign master_clock_out_pin_pulldown =
      clkOutPad_r[`BIT_CKO_PULLDN];

   // subsystem enables; memory controller gates the ADC, DAC and engine enables
   assign memAccessEn = memEn_r;
   assign adcEn = adcEn_r;
   assign dmicEn = dmicEn_r;
   assign dacEn = dacEn_r;
   assign engineEn = engineEn_r;
   assign serialPortEn = serialEn_r;
   assign recordRouteEn = recRouteEn_r;
   assign playbackRouteEn = playRouteEn_r;
   assign clockGenEn = clkGenEn_r;
   assign dejitterBypass = bypass_r;

   // strobes from the serial port domain: two flops, then edge detect
   always @(posedge core_clk) begin
      if (rst) begin
         playSync_r <= 3'h0;
         recSync_r <= 3'h0;
         playMeta_r <= {DATA_W{1'b0}};
         playSyncData_r <= {DATA_W{1'b0}};
      end else begin
         playSync_r <= {playSync_r[1:0], playStrobeAsync};
         recSync_r <= {recSync_r[1:0], recFrameAsync};
         // sample word passes the same two flops as its strobe
         playMeta_r <= playDataAsync;
         playSyncData_r <= playMeta_r;
      end
   end

   assign playRaw = playSync_r[1] & ~playSync_r[2];
   assign recRaw = recSync_r[1] & ~recSync_r[2];
   assign playEdge = playRaw & serialPortEn & playbackRouteEn;
   assign recEdge = recRaw & serialPortEn & recordRouteEn &
      engineEn;

   jitter_window_filter #(
      .DATA_W(DATA_W)
   ) u_play_filter (
      .core_clk(core_clk),
      .rst(rst),
      .windowSize(jitterWin_r),
      .strobeIn(playEdge),
      .dataIn(playSyncData_r),
      .strobeOut(playStrobe),
      .dataOut(playData)
   );

   jitter_window_filter #(
      .DATA_W(DATA_W)
   ) u_rec_filter (
      .core_clk(core_clk),
      .rst(rst),
      .windowSize(jitterWin_r),
      .strobeIn(recEdge),
      .dataIn(recDataIn),
      .strobeOut(recStrobe),
      .dataOut(recData)
   );
endmodule // pad_dejitter_power_config
